// [hw/fps_consec.sv]
`timescale 1ns/1ns
// Counts consecutive switching cycles whose sample meets a fault condition.
module fps_consec #(
    parameter int unsigned COUNT = fps_pkg::FAULT_CONSEC
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic sample,
    input  wire logic hit,
    output logic      trip
);
    import fps_pkg::*;

    localparam int unsigned CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          trip;
    } fps_consec_st_t;

    fps_consec_st_t st_q;
    fps_consec_st_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.trip = 1'b0;
        if (sample) begin
            if (!hit) begin
                st_d.count = '0;
            end else if (st_q.count == LAST) begin
                st_d.count = '0;
                st_d.trip  = 1'b1;
            end else begin
                st_d.count = st_q.count + CW'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign trip = st_q.trip;

endmodule // fps_consec

// [hw/fps_pkg.sv]
package fps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and time base.
    localparam int unsigned CLK_PERIOD_NS       = 100;

    // Least times are rounded up to whole clock cycles.
    localparam int unsigned BROWN_IN_QUALIFY_US = 100;
    localparam int unsigned BROWN_IN_CYC        =
        (BROWN_IN_QUALIFY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BROWN_OUT_QUALIFY_MS = 50;
    localparam int unsigned BROWN_OUT_CYC       =
        (BROWN_OUT_QUALIFY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EXT_LOW_MS          = 32;
    localparam int unsigned EXT_LOW_CYC         =
        (EXT_LOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UNDERVOLT_STARTUP_BLANK_MS = 20;
    localparam int unsigned UVP_BLANK_CYC       =
        (UNDERVOLT_STARTUP_BLANK_MS * 1000000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned LEB_NS              = 250;
    localparam int unsigned LEB_CYC             =
        (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHORT_DELAY_NS      = 4000;
    localparam int unsigned SHORT_CYC           =
        (SHORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_DELAY_NS     = 1500;
    localparam int unsigned SAMPLE_DELAY_CYC    =
        (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Consecutive switching cycles that qualify a sampled fault.
    localparam int unsigned FAULT_CONSEC        = 7;

    ////////////////////////////////////////////////////////////////////////
    // Counter widths and qualifier count.
    localparam int unsigned TMR_W               = 20;
    localparam int unsigned SHORT_W             = 8;
    localparam int unsigned NUM_CONSEC          = 5;

    // Index of each consecutive-cycle qualifier.
    localparam int unsigned IDX_OVP             = 0;
    localparam int unsigned IDX_UVP             = 1;
    localparam int unsigned IDX_EXT_HIGH        = 2;
    localparam int unsigned IDX_FAST_OC         = 3;
    localparam int unsigned IDX_SHORT           = 4;

    ////////////////////////////////////////////////////////////////////////
    // Comparator decisions from the analog front end, all asynchronous.
    typedef struct packed {
        logic line_above_brown_in;
        logic line_below_brown_out;
        logic supply_start_ok;
        logic supply_maintain_low;
        logic demag_over;
        logic demag_under;
        logic ext_above_high;
        logic ext_below_low;
        logic cs_fast_overcurrent;
        logic cs_above_short;
        logic cs_limit;
        logic pwm_cmp;
        logic feedback_below_min;
        logic int_ot_trip;
        logic int_ot_release;
        logic cycle_start;
    } fps_cmp_t;

    localparam int unsigned CMP_W = $bits(fps_cmp_t);

    typedef struct packed {
        logic output_overvoltage_fault;
        logic output_undervoltage_fault;
        logic external_high_fault;
        logic external_low_fault;
        logic fast_overcurrent_fault;
        logic sense_short_fault;
    } fps_fault_t;

    typedef enum logic [1:0] {
        MODE_QUALIFY = 2'b00,
        MODE_RUN     = 2'b01,
        MODE_FAULT   = 2'b10
    } fps_mode_t;

endpackage

// [hw/fps_supervisor.sv]
`timescale 1ns/1ns
//
// Operation
// - Start after 100us brown-in and start supply.
// - Brown-out for 50ms stops until brown-in.
// - Sampled demag over/under seven cycles shuts down.
// - Undervoltage ignored during start-up blanking.
// - Delayed external sample high seven cycles trips.
// - External low sampled 100ns before gate fall.
// - External low for 32ms trips temperature fault.
// - External faults stop drive until lockout reset.
// - Fast overcurrent seven cycles halts switching.
// - Sense short compared 4us after gate rise.
// - Sense below short seven cycles disables drive.
// - Internal over-temperature with hysteresis.
// - Feedback below 1.2V stops drive pulses.
// - Maintain threshold enables high charging current.
// - 250ns blanking from each gate rise.
// - Blanking ignores limit and PWM comparators.
module fps_supervisor #(
    parameter int unsigned BROWN_OUT_CYCLES    = fps_pkg::BROWN_OUT_CYC,
    parameter int unsigned EXT_LOW_CYCLES      = fps_pkg::EXT_LOW_CYC,
    parameter int unsigned UVP_BLANK_CYCLES    = fps_pkg::UVP_BLANK_CYC,
    parameter int unsigned SAMPLE_DELAY_CYCLES = fps_pkg::SAMPLE_DELAY_CYC
) (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire fps_pkg::fps_cmp_t  cmp_in,
    output logic                    gate_drive,
    output logic                    charger_high_en,
    output logic                    switching_enabled,
    output logic                    internal_ot_active,
    output fps_pkg::fps_fault_t     faults
);
    import fps_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Limits, cast once to the widths of the counters they meet.
    localparam logic [TMR_W-1:0]   BIN_LIM  = TMR_W'(BROWN_IN_CYC);
    localparam logic [TMR_W-1:0]   BOUT_LIM = TMR_W'(BROWN_OUT_CYCLES);
    localparam logic [TMR_W-1:0]   LOW_LIM  = TMR_W'(EXT_LOW_CYCLES);
    localparam logic [TMR_W-1:0]   UVP_LIM  = TMR_W'(UVP_BLANK_CYCLES);
    localparam logic [SHORT_W-1:0] LEB_LD   = SHORT_W'(LEB_CYC - 1);
    localparam logic [SHORT_W-1:0] SHORT_AT = SHORT_W'(SHORT_CYC);
    localparam logic [SHORT_W-1:0] SMP_LD   = SHORT_W'(SAMPLE_DELAY_CYCLES);
    localparam logic [SHORT_W-1:0] SHORT_ONE = SHORT_W'(1);
    localparam logic [TMR_W-1:0]   TMR_ONE   = TMR_W'(1);

    typedef struct packed {
        fps_cmp_t            s1;
        fps_cmp_t            s2;
        fps_cmp_t            s3;
        fps_cmp_t            flt;
        logic                cycle_prev;
        fps_mode_t           mode;
        logic                start_seen;
        logic [TMR_W-1:0]    bin_tmr;
        logic [TMR_W-1:0]    bout_tmr;
        logic [TMR_W-1:0]    uvp_tmr;
        logic [TMR_W-1:0]    low_tmr;
        logic                low_run;
        logic                gate;
        logic [SHORT_W-1:0]  leb;
        logic [SHORT_W-1:0]  rise_tmr;
        logic                rise_run;
        logic [SHORT_W-1:0]  smp;
        logic                smp_run;
        logic                fast_oc_hit;
        logic                ot_act;
        logic                chg;
        logic                run;
        fps_fault_t          fault;
    } fps_state_t;

    fps_state_t st_q;
    fps_state_t st_d;

    logic [NUM_CONSEC-1:0] cons_sample;
    logic [NUM_CONSEC-1:0] cons_hit;
    logic [NUM_CONSEC-1:0] cons_trip;

    ////////////////////////////////////////////////////////////////////////
    // One qualifier per sampled fault except external low; they share the same counting law.
    for (genvar i = 0; i < NUM_CONSEC; i++) begin : g_consec
        fps_consec #(
            .COUNT (FAULT_CONSEC)
        ) u_consec (
            .clock  (clock),
            .rst_n  (rst_n),
            .sample (cons_sample[i]),
            .hit    (cons_hit[i]),
            .trip   (cons_trip[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [CMP_W-1:0] agree;
        logic             rise;
        logic             gate_fall;
        logic             halted;

        st_d        = st_q;
        cons_sample = '0;
        cons_hit    = '0;
        gate_fall   = 1'b0;
        agree       = '0;
        rise        = 1'b0;
        halted      = 1'b0;

        // Three-stage synchroniser; a level counts once stages two and
        // three agree, which also rejects single-cycle glitches.
        st_d.s1  = cmp_in;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        agree    = ~(st_q.s2 ^ st_q.s3);
        st_d.flt = fps_cmp_t'((st_q.s2 & agree) | (st_q.flt & ~agree));

        st_d.cycle_prev = st_q.flt.cycle_start;
        rise = st_q.flt.cycle_start & ~st_q.cycle_prev;

        if (st_q.flt.supply_start_ok) begin
            st_d.start_seen = 1'b1;
        end

        // Trip and release sit at different thresholds, so the flag
        // only clears once the die has cooled past the lower point.
        if (st_q.flt.int_ot_trip) begin
            st_d.ot_act = 1'b1;
        end else if (st_q.flt.int_ot_release) begin
            st_d.ot_act = 1'b0;
        end

        // Charger held off in a fault so the supply can reach lockout.
        st_d.chg = st_q.flt.supply_maintain_low
                   && (st_q.mode != MODE_FAULT);

        ////////////////////////////////////////////////////////////////////
        // Gate pulse generation.
        halted = st_q.flt.feedback_below_min || st_q.ot_act;
        if (st_q.gate) begin
            if (st_q.flt.cs_fast_overcurrent) begin
                st_d.fast_oc_hit = 1'b1;
            end
            if (st_q.leb != '0) begin
                st_d.leb = st_q.leb - SHORT_ONE;
            end else if (st_q.flt.cs_limit || st_q.flt.pwm_cmp) begin
                st_d.gate = 1'b0;
                gate_fall = 1'b1;
            end
        end else if (st_q.mode == MODE_RUN && rise && !halted) begin
            st_d.gate     = 1'b1;
            st_d.leb      = LEB_LD;
            st_d.rise_tmr = '0;
            st_d.rise_run = 1'b1;
            st_d.fast_oc_hit = 1'b0;
        end

        // Sense-short comparison at a fixed point into the on time.
        if (st_q.rise_run) begin
            if (!st_q.gate) begin
                st_d.rise_run = 1'b0;
            end else if (st_q.rise_tmr == SHORT_AT) begin
                st_d.rise_run          = 1'b0;
                cons_sample[IDX_SHORT] = 1'b1;
                cons_hit[IDX_SHORT]    = ~st_q.flt.cs_above_short;
            end else begin
                st_d.rise_tmr = st_q.rise_tmr + SHORT_ONE;
            end
        end

        if (gate_fall) begin
            st_d.smp      = SMP_LD;
            st_d.smp_run  = 1'b1;
            cons_sample[IDX_FAST_OC] = 1'b1;
            cons_hit[IDX_FAST_OC]    = st_q.fast_oc_hit
                                       || st_q.flt.cs_fast_overcurrent;
            // The gate pin drops on the next edge, one period after
            // this value was taken.
            if (st_q.flt.ext_below_low) begin
                st_d.low_run = 1'b1;
            end else begin
                st_d.low_run = 1'b0;
                st_d.low_tmr = '0;
            end
        end

        // Delayed sample of output and external high comparators.
        if (st_q.smp_run) begin
            if (st_q.smp <= SHORT_ONE) begin
                st_d.smp_run = 1'b0;
                cons_sample[IDX_OVP]      = 1'b1;
                cons_hit[IDX_OVP]         = st_q.flt.demag_over;
                cons_sample[IDX_UVP]      = 1'b1;
                cons_hit[IDX_UVP]         = st_q.flt.demag_under
                                            && (st_q.uvp_tmr >= UVP_LIM);
                cons_sample[IDX_EXT_HIGH] = 1'b1;
                cons_hit[IDX_EXT_HIGH]    = st_q.flt.ext_above_high;
            end else begin
                st_d.smp = st_q.smp - SHORT_ONE;
            end
        end

        // Undervoltage blanking window from each start of switching.
        if (st_q.mode == MODE_RUN && st_q.uvp_tmr < UVP_LIM) begin
            st_d.uvp_tmr = st_q.uvp_tmr + TMR_ONE;
        end

        // External low condition timed continuously between samples.
        if (st_q.low_run && st_q.low_tmr < LOW_LIM) begin
            st_d.low_tmr = st_q.low_tmr + TMR_ONE;
        end

        ////////////////////////////////////////////////////////////////////
        // Fault latching; only the lockout reset clears these.
        if (cons_trip[IDX_OVP]) begin
            st_d.fault.output_overvoltage_fault = 1'b1;
        end
        if (cons_trip[IDX_UVP]) begin
            st_d.fault.output_undervoltage_fault = 1'b1;
        end
        if (cons_trip[IDX_EXT_HIGH]) begin
            st_d.fault.external_high_fault = 1'b1;
        end
        if (st_q.low_run && st_q.low_tmr >= LOW_LIM) begin
            st_d.fault.external_low_fault = 1'b1;
        end
        if (cons_trip[IDX_FAST_OC]) begin
            st_d.fault.fast_overcurrent_fault = 1'b1;
        end
        if (cons_trip[IDX_SHORT]) begin
            st_d.fault.sense_short_fault = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // Mode sequencing.
        case (st_q.mode)
            MODE_QUALIFY: begin
                st_d.bout_tmr = '0;
                if (!st_q.flt.line_above_brown_in) begin
                    st_d.bin_tmr = '0;
                end else if (st_q.bin_tmr < BIN_LIM) begin
                    st_d.bin_tmr = st_q.bin_tmr + TMR_ONE;
                end
                if (st_q.bin_tmr >= BIN_LIM && st_q.start_seen) begin
                    st_d.mode    = MODE_RUN;
                    st_d.uvp_tmr = '0;
                end
            end
            MODE_RUN: begin
                st_d.bin_tmr = '0;
                if (!st_q.flt.line_below_brown_out) begin
                    st_d.bout_tmr = '0;
                end else if (st_q.bout_tmr < BOUT_LIM) begin
                    st_d.bout_tmr = st_q.bout_tmr + TMR_ONE;
                end
                if (st_q.bout_tmr >= BOUT_LIM) begin
                    st_d.mode = MODE_QUALIFY;
                end
            end
            MODE_FAULT: begin
                st_d.mode = MODE_FAULT;
            end
            default: begin
                st_d.mode = MODE_FAULT;
            end
        endcase

        if (st_d.fault != '0) begin
            st_d.mode = MODE_FAULT;
        end

        // Any exit from running cuts the pulse at once.
        if (st_d.mode != MODE_RUN) begin
            st_d.gate     = 1'b0;
            st_d.rise_run = 1'b0;
            st_d.smp_run  = 1'b0;
        end
        st_d.run = (st_d.mode == MODE_RUN);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign gate_drive         = st_q.gate;
    assign charger_high_en    = st_q.chg;
    assign switching_enabled  = st_q.run;
    assign internal_ot_active = st_q.ot_act;
    assign faults             = st_q.fault;

endmodule // fps_supervisor

// [test/fps_analog_model.sv]
`timescale 1ns/1ns
// Stands for the comparators, the oscillator and the switch current ramp.
module fps_analog_model #(
    parameter int unsigned PERIOD = 80
) (
    input  wire logic              clock,
    input  wire logic              gate_drive,
    input  wire logic [7:0]        on_cycles,
    input  wire fps_pkg::fps_cmp_t env,
    output fps_pkg::fps_cmp_t      cmp_in
);
    import fps_pkg::*;
    logic [7:0] osc_q = 8'h00;
    logic [7:0] on_q  = 8'h00;

    ////////////////////////////////////////
    always_ff @(posedge clock) begin
        osc_q <= (osc_q == 8'(PERIOD - 1)) ? 8'h00 : osc_q + 8'h01;
        on_q  <= gate_drive ? on_q + {7'h00, on_q != 8'hFF} : 8'h00;
    end

    // No switch current flows while the gate is off, so the sense
    // comparators only report during a pulse; a stuck limit stays stuck.
    always_comb begin
        cmp_in = env;
        cmp_in.cycle_start = (osc_q < 8'h04);
        cmp_in.cs_fast_overcurrent = env.cs_fast_overcurrent & gate_drive;
        cmp_in.cs_above_short = env.cs_above_short & gate_drive;
        cmp_in.cs_limit = env.cs_limit | (gate_drive & (on_q >= on_cycles));
    end
endmodule // fps_analog_model

// [test/fps_checker.sv]
`timescale 1ns/1ns
module fps_checker #(
    parameter int unsigned BROWN_OUT_CYCLES = fps_pkg::BROWN_OUT_CYC
) (
    input wire logic                clock,
    input wire logic                rst_n,
    input wire fps_pkg::fps_cmp_t   cmp_in,
    input wire logic                gate_drive,
    input wire logic                charger_high_en,
    input wire logic                switching_enabled,
    input wire logic                internal_ot_active,
    input wire fps_pkg::fps_fault_t faults
);
    import fps_pkg::*;
    // Raw run lengths of the line comparators; without single-cycle glitches the input
    // filter only adds delay, so the design may never act before these counts are reached.
    logic [19:0] above_q;
    logic [19:0] below_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            above_q <= '0;
            below_q <= '0;
        end else begin
            above_q <= cmp_in.line_above_brown_in ? above_q + 20'h0_0001 : '0;
            below_q <= cmp_in.line_below_brown_out ? below_q + 20'h0_0001 : '0;
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_gate_needs_run:
        assert property (gate_drive |-> switching_enabled)
        else $error("gate high outside run mode");
    a_fault_halts:
        assert property (faults != '0 |-> !gate_drive && !switching_enabled)
        else $error("drive still active with a latched fault");
    a_blank_width:
        assert property ($rose(gate_drive) |->
            (gate_drive || faults != '0 || !switching_enabled) [*3])
        else $error("gate pulse cut inside blanking");
    a_faults_sticky:
        assert property ((faults & $past(faults)) == $past(faults))
        else $error("latched fault cleared without reset");
    a_feedback_holds:
        assert property (cmp_in.feedback_below_min [*8] |=> !$rose(gate_drive))
        else $error("pulse issued at low feedback");
    a_ot_blocks:
        assert property (internal_ot_active |=> !$rose(gate_drive))
        else $error("pulse issued while over temperature");
    a_ot_trip:
        assert property (cmp_in.int_ot_trip [*8] |-> internal_ot_active)
        else $error("over temperature not flagged");
    a_ot_release:
        assert property ((cmp_in.int_ot_release && !cmp_in.int_ot_trip) [*8]
            |-> !internal_ot_active)
        else $error("over temperature not released");
    a_charger_on:
        assert property ((cmp_in.supply_maintain_low && faults == '0) [*8]
            |-> charger_high_en)
        else $error("charger not enabled at maintain level");
    a_brown_in_time:
        assert property ($rose(switching_enabled) |-> above_q >= BROWN_IN_CYC)
        else $error("run entered before line qualified");
    a_brown_out_time:
        assert property ($fell(switching_enabled) && faults == '0
            |-> below_q >= BROWN_OUT_CYCLES)
        else $error("run left before brown-out time");

    c_pulse: cover property ($rose(gate_drive));
    c_overcurrent: cover property ($rose(faults.fast_overcurrent_fault));
    c_brown_out: cover property ($fell(switching_enabled) && faults == '0);
endmodule // fps_checker

bind fps_supervisor fps_checker #(
    .BROWN_OUT_CYCLES(BROWN_OUT_CYCLES)
) fps_checker_inst (
    .clock             (clock),
    .rst_n             (rst_n),
    .cmp_in            (cmp_in),
    .gate_drive        (gate_drive),
    .charger_high_en   (charger_high_en),
    .switching_enabled (switching_enabled),
    .internal_ot_active(internal_ot_active),
    .faults            (faults)
);

// [test/test_fps_supervisor.sv]
`timescale 1ns/1ns
module test_fps_supervisor;
    import fps_pkg::*;
    localparam int NROWS = 10;
    // Each row flips comparator bits of a healthy line and gives the
    // latched faults and the {run, pulsed, hot, charging} status.
    logic [15:0] row_mask [NROWS] = '{16'h0000, 16'h0800, 16'h0400,
        16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0008, 16'h0004, 16'h1002};
    logic [5:0]  row_flt [NROWS] = '{6'h00, 6'h20, 6'h10, 6'h08, 6'h04,
        6'h02, 6'h01, 6'h00, 6'h00, 6'h00};
    logic [3:0]  row_sts [NROWS] = '{4'hC, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
        4'h4, 4'h8, 4'hA, 4'hD};
    logic        clock;
    logic        rst_n;
    logic        gate_prev;
    logic [7:0]  on_cycles;
    fps_cmp_t    env;
    fps_cmp_t    base;
    fps_cmp_t    cmp_in;
    logic        gate_drive;
    logic        charger_high_en;
    logic        switching_enabled;
    logic        internal_ot_active;
    fps_fault_t  faults;
    int          bad_count;
    int          checks;
    int          cycles;
    int          rises;

    fps_supervisor #(
        .BROWN_OUT_CYCLES   (200),
        .EXT_LOW_CYCLES     (300),
        .UVP_BLANK_CYCLES   (100),
        .SAMPLE_DELAY_CYCLES(4)
    ) fps_supervisor_inst (
        .clock             (clock),
        .rst_n             (rst_n),
        .cmp_in            (cmp_in),
        .gate_drive        (gate_drive),
        .charger_high_en   (charger_high_en),
        .switching_enabled (switching_enabled),
        .internal_ot_active(internal_ot_active),
        .faults            (faults)
    );

    fps_analog_model fps_analog_model_inst (
        .clock     (clock),
        .gate_drive(gate_drive),
        .on_cycles (on_cycles),
        .env       (env),
        .cmp_in    (cmp_in)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Gate edges are counted on the falling clock edge, where the
    // output launched by the rising edge has settled.
    always @(negedge clock) begin
        if (gate_drive === 1'b1 && gate_prev === 1'b0) rises++;
        gate_prev = gate_drive;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            final_report();
        end
    end

    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs always move 10 ns after an edge, never on it.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask

    task automatic start(input fps_cmp_t e);
        rst_n = 1'b0;
        env = e;
        tick(8);
        check({2'b00, faults}, 8'h00);
        check({6'h00, gate_drive, switching_enabled}, 8'h00);
        rst_n = 1'b1;
    endtask

    task automatic wait_gate(input logic lvl);
        int n;
        n = 0;
        while (gate_drive !== lvl && n < 1500) begin
            tick(1);
            n++;
        end
        check({7'h00, gate_drive}, {7'h00, lvl});
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        int n;
        logic [3:0] sts;
        rst_n = 1'b0;
        gate_prev = 1'b0;
        on_cycles = 8'h32;
        bad_count = 0;
        checks = 0;
        cycles = 0;
        rises = 0;
        base = '0;
        base.line_above_brown_in = 1'b1;
        base.supply_start_ok = 1'b1;
        base.cs_above_short = 1'b1;
        env = base;
        for (int i = 0; i < NROWS; i++) begin
            start(fps_cmp_t'(base ^ row_mask[i]));
            rises = 0;
            tick(2500);
            sts = {switching_enabled, rises != 0, internal_ot_active,
                   charger_high_en};
            check({2'b00, faults}, {2'b00, row_flt[i]});
            check({4'h0, sts}, {4'h0, row_sts[i]});
        end
        // A comparator stuck high from the leading edge still gets 3 cycles.
        for (int k = 0; k < 2; k++) begin
            start(fps_cmp_t'(base ^ ((k == 0) ? 16'h0020 : 16'h0010)));
            wait_gate(1'b1);
            n = 0;
            while (gate_drive === 1'b1 && n < 20) begin
                tick(1);
                n++;
            end
            check(8'(n), 8'h03);
        end
        on_cycles = 8'h0A;
        start(base);
        for (int i = 0; i < 14; i++) begin
            env.cs_fast_overcurrent = (i != 6);
            wait_gate(1'b1);
            wait_gate(1'b0);
            if (i == 12) check({2'b00, faults}, 8'h00);
        end
        tick(4);
        check({2'b00, faults}, 8'h02);
        start(base);
        tick(1200);
        env.line_above_brown_in = 1'b0;
        env.line_below_brown_out = 1'b1;
        tick(150);
        check({7'h00, switching_enabled}, 8'h01);
        env.line_below_brown_out = 1'b0;
        tick(10);
        env.line_below_brown_out = 1'b1;
        tick(250);
        check({6'h00, switching_enabled, gate_drive}, 8'h00);
        check({2'b00, faults}, 8'h00);
        env = base;
        tick(900);
        check({7'h00, switching_enabled}, 8'h00);
        tick(300);
        check({7'h00, switching_enabled}, 8'h01);
        // The hold-off must outlast the trip input until release is seen.
        env.int_ot_trip = 1'b1;
        tick(10);
        check({7'h00, internal_ot_active}, 8'h01);
        env.int_ot_trip = 1'b0;
        tick(10);
        check({7'h00, internal_ot_active}, 8'h01);
        env.int_ot_release = 1'b1;
        tick(10);
        check({7'h00, internal_ot_active}, 8'h00);
        final_report();
    end
endmodule // test_fps_supervisor
